// [design/cms_status_bank.sv]
// Purpose: Read-only loop and synthesizer status bank on AXI4-Lite.
// Assumes: Status inputs are synchronous to clk.
// Notes:   Event status bits clear on read; mask gates the interrupt.
`timescale 1ns/1ps
module cms_status_bank
  import cms_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire cms_pkg::cms_loop_t [2:0]    loop_in,
  input  wire logic [3:0]                  loop1_ref_index,
  input  wire logic [3:0]                  loop3_ref_index,
  input  wire cms_pkg::cms_synth_t         first_synthesizer,
  input  wire logic [cms_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [cms_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic                             irq
);
  import cms_pkg::*;

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // Word index of a byte address; low two bits are ignored.
  function automatic logic [IDX_W-1:0] cms_index
    (input logic [ADDR_W-1:0] addr);
    cms_index = addr[ADDR_W-1:2];
  endfunction : cms_index

  // ----------------------------------------------------------------
  // Status images
  // ----------------------------------------------------------------
  logic [2:0][7:0] loop_reg;
  logic [2:0][7:0] next_loop_reg;
  logic [7:0]      ref10_reg;
  logic [7:0]      next_ref10_reg;
  logic [7:0]      ref32_reg;
  logic [7:0]      next_ref32_reg;
  logic            vco_out;
  logic            next_vco_out;
  logic            align_a_done;
  logic            next_align_a_done;
  logic            align_b_done;
  logic            next_align_b_done;
  logic [7:0]      synth_reg;

  // Each loop register mirrors its loop; bits 4:2 stay zero.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_loop
      always_comb
      begin
        next_loop_reg[g]                  = REG_RESET;
        next_loop_reg[g][LOOP_SLOPE_BIT]  = loop_in[g].slope_hit;
        next_loop_reg[g][LOOP_MEMORY_BIT] = loop_in[g].memory_hit;
        next_loop_reg[g][LOOP_RANGE_BIT]  = loop_in[g].range_hit;
        next_loop_reg[g][LOOP_HOLD_BIT]   =
          loop_in[g].holdover_active;
        next_loop_reg[g][LOOP_UNLOCK_BIT] = ~loop_in[g].locked;
      end
    end
  endgenerate

  // Reference choice is shown as given; meaningful only in auto mode.
  always_comb
  begin
    next_ref10_reg = REG_RESET;
    next_ref10_reg[REF_SEL_LSB +: 4] = loop1_ref_index;
    next_ref32_reg = REG_RESET;
    next_ref32_reg[REF_SEL_LSB +: 4] = loop3_ref_index;
  end

  // Alignment done is sticky; a disabled output or synthesizer wins
  // over a completion pulse, since a disabled path cannot be aligned.
  always_comb
  begin
    next_vco_out = ~first_synthesizer.vco_locked;
    next_align_a_done = align_a_done | first_synthesizer.align_a_pulse;
    if (!first_synthesizer.enabled || !first_synthesizer.out_a_enabled)
    begin
      next_align_a_done = 1'b0;
    end
    next_align_b_done = align_b_done | first_synthesizer.align_b_pulse;
    if (!first_synthesizer.enabled || !first_synthesizer.out_b_enabled)
    begin
      next_align_b_done = 1'b0;
    end
  end

  // Register the status images.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      loop_reg     <= '0;
      ref10_reg    <= REG_RESET;
      ref32_reg    <= REG_RESET;
      vco_out      <= 1'b0;
      align_a_done <= 1'b0;
      align_b_done <= 1'b0;
    end
    else
    begin
      loop_reg     <= next_loop_reg;
      ref10_reg    <= next_ref10_reg;
      ref32_reg    <= next_ref32_reg;
      vco_out      <= next_vco_out;
      align_a_done <= next_align_a_done;
      align_b_done <= next_align_b_done;
    end
  end

  // Synthesizer view: bits 7:6, 3 and 1:0 are reserved zero.
  always_comb
  begin
    synth_reg                  = REG_RESET;
    synth_reg[SYN_ALIGN_B_BIT] = align_b_done;
    synth_reg[SYN_ALIGN_A_BIT] = align_a_done;
    synth_reg[SYN_VCO_BIT]     = vco_out;
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic [7:0]  event_raw;
  logic [7:0]  event_stat;
  logic [7:0]  next_event_stat;
  logic [7:0]  event_mask;
  logic [7:0]  next_event_mask;
  logic        next_irq;
  logic        stat_read;
  logic        mask_write;
  logic [31:0] wdata_q;

  // Events are rising edges of unlock, holdover, VCO fault, alignment.
  always_comb
  begin
    event_raw = '0;
    for (int i = 0; i < 3; i++)
    begin
      event_raw[EV_UNLOCK_LSB + i] =
        next_loop_reg[i][LOOP_UNLOCK_BIT] & ~loop_reg[i][LOOP_UNLOCK_BIT];
      event_raw[EV_HOLD_LSB + i] =
        next_loop_reg[i][LOOP_HOLD_BIT] & ~loop_reg[i][LOOP_HOLD_BIT];
    end
    event_raw[EV_VCO_BIT]   = next_vco_out & ~vco_out;
    event_raw[EV_ALIGN_BIT] = (next_align_a_done & ~align_a_done) |
                              (next_align_b_done & ~align_b_done);
  end

  // A new event in the cycle of the clearing read is kept.
  always_comb
  begin
    next_event_stat = (stat_read ? 8'h00 : event_stat) | event_raw;
    next_event_mask = mask_write ? wdata_q[7:0] : event_mask;
    next_irq        = |(next_event_stat & next_event_mask);
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic              aw_have;
  logic              next_aw_have;
  logic              w_have;
  logic              next_w_have;
  logic [IDX_W-1:0]  aw_idx;
  logic [IDX_W-1:0]  next_aw_idx;
  logic [31:0]       next_wdata_q;
  logic [3:0]        wstrb_q;
  logic [3:0]        next_wstrb_q;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_awready;
  logic              next_wready;
  logic              w_mapped;

  // Address and data are taken in either order; response follows both.
  always_comb
  begin
    next_aw_have = aw_have;
    next_aw_idx  = aw_idx;
    next_w_have  = w_have;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    mask_write   = 1'b0;
    w_mapped     = 1'b0;
    if (awvalid && awready)
    begin
      next_aw_have = 1'b1;
      next_aw_idx  = cms_index(awaddr);
    end
    if (wvalid && wready)
    begin
      next_w_have  = 1'b1;
      next_wdata_q = wdata;
      next_wstrb_q = wstrb;
    end
    if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (aw_have && w_have && !bvalid)
    begin
      // Read-only images accept the write and ignore it.
      if (aw_idx == IDX_EVENT_MASK)
      begin
        w_mapped   = 1'b1;
        mask_write = wstrb_q[0];
      end
      else if (aw_idx == IDX_LOOP1_MON || aw_idx == IDX_LOOP2_MON ||
               aw_idx == IDX_LOOP3_MON || aw_idx == IDX_REF_1_0 ||
               aw_idx == IDX_REF_3_2 || aw_idx == IDX_FIRST_SYNTHESIZER ||
               aw_idx == IDX_EVENT_STAT)
      begin
        w_mapped = 1'b1;
      end
      next_bresp   = w_mapped ? RESP_OKAY : RESP_SLV;
      next_bvalid  = 1'b1;
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
    end
    next_awready = ~next_aw_have & ~next_bvalid;
    next_wready  = ~next_w_have & ~next_bvalid;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  cms_rd_state_t     rd_state;
  cms_rd_state_t     next_rd_state;
  logic              next_arready;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [IDX_W-1:0]  r_idx;

  // One read at a time; data is answered the cycle after acceptance.
  always_comb
  begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    stat_read     = 1'b0;
    r_idx         = cms_index(araddr);
    case (rd_state)
      CMS_RD_IDLE:
      begin
        if (arvalid)
        begin
          next_rd_state = CMS_RD_DATA;
          next_rdata    = 32'h0000_0000;
          next_rresp    = RESP_OKAY;
          if (r_idx == IDX_LOOP1_MON)
            next_rdata[7:0] = loop_reg[0];
          else if (r_idx == IDX_LOOP2_MON)
            next_rdata[7:0] = loop_reg[1];
          else if (r_idx == IDX_LOOP3_MON)
            next_rdata[7:0] = loop_reg[2];
          else if (r_idx == IDX_REF_1_0)
            next_rdata[7:0] = ref10_reg;
          else if (r_idx == IDX_REF_3_2)
            next_rdata[7:0] = ref32_reg;
          else if (r_idx == IDX_FIRST_SYNTHESIZER)
            next_rdata[7:0] = synth_reg;
          else if (r_idx == IDX_EVENT_STAT)
          begin
            next_rdata[7:0] = event_stat;
            stat_read       = 1'b1;
          end
          else if (r_idx == IDX_EVENT_MASK)
            next_rdata[7:0] = event_mask;
          else
            next_rresp = RESP_SLV;
        end
      end
      CMS_RD_DATA:
      begin
        if (rready)
        begin
          next_rd_state = CMS_RD_IDLE;
        end
      end
      default:
      begin
        next_rd_state = CMS_RD_IDLE;
      end
    endcase
    next_rvalid  = (next_rd_state == CMS_RD_DATA);
    next_arready = (next_rd_state == CMS_RD_IDLE);
  end

  // ----------------------------------------------------------------
  // Bus and interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_have    <= 1'b0;
      aw_idx     <= '0;
      w_have     <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      awready    <= 1'b1;
      wready     <= 1'b1;
      rd_state   <= CMS_RD_IDLE;
      arready    <= 1'b1;
      rvalid     <= 1'b0;
      rdata      <= 32'h0000_0000;
      rresp      <= RESP_OKAY;
      event_stat <= REG_RESET;
      event_mask <= REG_RESET;
      irq        <= 1'b0;
    end
    else
    begin
      aw_have    <= next_aw_have;
      aw_idx     <= next_aw_idx;
      w_have     <= next_w_have;
      wdata_q    <= next_wdata_q;
      wstrb_q    <= next_wstrb_q;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      awready    <= next_awready;
      wready     <= next_wready;
      rd_state   <= next_rd_state;
      arready    <= next_arready;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
      event_stat <= next_event_stat;
      event_mask <= next_event_mask;
      irq        <= next_irq;
    end
  end

endmodule : cms_status_bank

// [dv/cms_status_bank_sva.sv]
// Purpose: Port assertions for the clock monitor status bank.
// Assumes: Status inputs are held steady for a few cycles before reads.
// Notes:   Image checks wait for three quiet cycles to cover the lag.
`timescale 1ns/1ps
module cms_status_bank_sva
(
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire cms_pkg::cms_loop_t [2:0]    loop_in,
  input wire logic [3:0]                  loop1_ref_index,
  input wire logic [3:0]                  loop3_ref_index,
  input wire cms_pkg::cms_synth_t         first_synthesizer,
  input wire logic [cms_pkg::ADDR_W-1:0]  araddr,
  input wire logic                        arvalid,
  input wire logic                        arready,
  input wire logic [31:0]                 rdata,
  input wire logic [1:0]                  rresp,
  input wire logic                        rvalid
);
  import cms_pkg::*;
  logic [IDX_W-1:0] rd_idx;
  logic [28:0]      seen;
  logic [1:0]       quiet;
  wire  [28:0]      now_in = {loop_in, loop1_ref_index, loop3_ref_index,
                              first_synthesizer};
  wire loop_rd = rd_idx inside {IDX_LOOP1_MON, IDX_LOOP2_MON, IDX_LOOP3_MON};
  wire mapped  = loop_rd || rd_idx inside {IDX_REF_1_0, IDX_REF_3_2,
                 IDX_FIRST_SYNTHESIZER, IDX_EVENT_STAT, IDX_EVENT_MASK};
  wire syn_rd  = rvalid && rd_idx == IDX_FIRST_SYNTHESIZER && quiet == 2'h3;
  cms_synth_t s;
  assign s = first_synthesizer;

  // Track the read index and how long the inputs have stood still, so
  // that image checks never race the one-cycle lag of the status copy.
  always_ff @(posedge clk)
  begin
    seen <= now_in;
    if (arvalid && arready)
      rd_idx <= araddr[ADDR_W-1:2];
    if (!rst_n || now_in != seen)
      quiet <= 2'h0;
    else if (quiet != 2'h3)
      quiet <= quiet + 2'h1;
  end

  function automatic logic [7:0] loop_img(input cms_loop_t l);
    return {l.slope_hit, l.memory_hit, l.range_hit, 3'h0,
            l.holdover_active, ~l.locked};
  endfunction : loop_img

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_loop_image: assert property (rvalid && loop_rd &&
    quiet == 2'h3 |-> rdata[7:0] == loop_img(loop_in[rd_idx[1:0] + 2'h1]))
    else $error("loop status image wrong");
  a_ref1_image: assert property (rvalid && rd_idx == IDX_REF_1_0 &&
    quiet == 2'h3 |-> rdata[7:0] == {loop1_ref_index, 4'h0})
    else $error("loop 1 reference choice wrong");
  a_ref3_image: assert property (rvalid && rd_idx == IDX_REF_3_2 &&
    quiet == 2'h3 |-> rdata[7:0] == {loop3_ref_index, 4'h0})
    else $error("loop 3 reference choice wrong");
  a_vco_flag: assert property (syn_rd |-> rdata[2] == !s.vco_locked
    && rdata[7:6] == 2'h0 && rdata[3] == 1'b0 && rdata[1:0] == 2'h0)
    else $error("synthesizer lock bit wrong");
  a_align_cleared: assert property (syn_rd |->
    !(rdata[4] && !(s.enabled && s.out_a_enabled)) &&
    !(rdata[5] && !(s.enabled && s.out_b_enabled)))
    else $error("alignment done shown while disabled");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_err: assert property (rvalid && !mapped |-> rresp == RESP_SLV)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (rvalid && mapped |-> rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");

  c_loop_read: cover property (rvalid && loop_rd && rdata[0]);
  c_align_seen: cover property (syn_rd && rdata[4]);
  c_unmapped: cover property (rvalid && !mapped);
endmodule : cms_status_bank_sva

bind cms_status_bank cms_status_bank_sva i_cms_status_bank_sva (.clk, .rst_n,
  .loop_in, .loop1_ref_index, .loop3_ref_index, .first_synthesizer, .araddr,
  .arvalid, .arready, .rdata, .rresp, .rvalid);

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the clock monitor status bank.
// Assumes: Status images settle within three cycles of an input change.
// Notes:   Reads and writes go through AXI4-Lite tasks only.
`timescale 1ns/1ps
module tb_top;
  import cms_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cms_loop_t [2:0] loop_in = {3{5'h01}};
  logic [3:0] loop1_ref_index = 4'h0;
  logic [3:0] loop3_ref_index = 4'h0;
  cms_synth_t first_synthesizer = 6'h3c;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [4:0] v;
  logic [7:0] x;
  int err_count = 0;
  int total_checks = 0;
  logic [IDX_W-1:0] ro_tab [6] = '{IDX_LOOP1_MON, IDX_LOOP2_MON,
    IDX_LOOP3_MON, IDX_REF_1_0, IDX_REF_3_2, IDX_FIRST_SYNTHESIZER};
  logic [5:0] s_tab [9] = '{6'h2c, 6'h3e, 6'h3d, 6'h34, 6'h36, 6'h31,
    6'h1c, 6'h1f, 6'h3c};
  logic [5:0] h_tab [9] = '{6'h2c, 6'h3c, 6'h3c, 6'h34, 6'h34, 6'h30,
    6'h1c, 6'h1c, 6'h3c};
  logic [7:0] e_tab [9] = '{8'h04, 8'h10, 8'h30, 8'h20, 8'h20, 8'h00,
    8'h00, 8'h00, 8'h00};

  cms_status_bank i_cms_status_bank (.clk, .rst_n, .loop_in,
    .loop1_ref_index, .loop3_ref_index, .first_synthesizer, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .irq);

  // 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Read one word; the answer is taken at the edge where rvalid is seen.
  // Ready stays high between calls, so back-to-back calls never drop
  // and raise it in one time step.
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] q,
                    output logic [1:0] rs);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    q = rdata;
    rs = rresp;
  endtask : rd

  task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] e,
                      input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] rs;
    rd(idx, q, rs);
    chk($sformatf("reg %h", idx), {24'h00_0000, e}, q);
    chk("rresp", 32'(er), 32'(rs));
  endtask : rchk

  // Address and data are offered together and each dropped once taken.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] q,
                    output logic [1:0] rs);
    awaddr <= {idx, 2'h0};
    wdata <= q;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end
    while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask : wr

  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, then writes that must leave the registers alone.
    for (int i = 0; i < 6; i++)
    begin
      rchk(ro_tab[i], 8'h00, RESP_OKAY);
      wr(ro_tab[i], 32'hffff_ffff, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
      rchk(ro_tab[i], 8'h00, RESP_OKAY);
    end
    rd(10'h200, d, r);
    chk("unmapped rresp", 32'(RESP_SLV), 32'(r));
    wr(10'h200, 32'h0000_0001, r);
    chk("unmapped bresp", 32'(RESP_SLV), 32'(r));
    // Walk each loop field on its own, the lock bit included.
    for (int i = 0; i < 3; i++)
      for (int k = 0; k < 5; k++)
      begin
        v = 5'h01 ^ (5'h10 >> k);
        x = {v[4:2], 3'h0, v[1], ~v[0]};
        loop_in[i] <= v;
        repeat (3) @(posedge clk);
        rchk(IDX_W'(i) + IDX_LOOP1_MON, x, RESP_OKAY);
        loop_in[i] <= 5'h01;
        @(posedge clk);
      end
    for (int k = 0; k < 16; k++)
    begin
      loop1_ref_index <= 4'(k);
      loop3_ref_index <= 4'(15 - k);
      repeat (3) @(posedge clk);
      rchk(IDX_REF_1_0, {4'(k), 4'h0}, RESP_OKAY);
      rchk(IDX_REF_3_2, {4'(15 - k), 4'h0}, RESP_OKAY);
    end
    // One-cycle stimulus, then a held level, then a read of the result.
    for (int i = 0; i < 9; i++)
    begin
      first_synthesizer <= s_tab[i];
      @(posedge clk);
      first_synthesizer <= h_tab[i];
      repeat (3) @(posedge clk);
      rchk(IDX_FIRST_SYNTHESIZER, e_tab[i], RESP_OKAY);
    end
    // Interrupt masked, then unmasked, then cleared by reading status.
    wr(IDX_EVENT_MASK, 32'h0000_0000, r);
    // Every event kind has fired once by now: unlock, holdover, VCO, align.
    rchk(IDX_EVENT_STAT, 8'hff, RESP_OKAY);
    loop_in[0] <= 5'h00;
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    rchk(IDX_EVENT_STAT, 8'h01, RESP_OKAY);
    rchk(IDX_EVENT_STAT, 8'h00, RESP_OKAY);
    loop_in[0] <= 5'h01;
    wr(IDX_EVENT_MASK, 32'h0000_0001, r);
    rchk(IDX_EVENT_MASK, 8'h01, RESP_OKAY);
    loop_in[0] <= 5'h00;
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rchk(IDX_EVENT_STAT, 8'h01, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    close_out();
  end

  // A hang is cut short here and reported as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : tb_top

// [pkg/cms_pkg.sv]
// Purpose: Constants and types for the clock monitor status bank.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Offsets are register indices; byte address is four times index.
package cms_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_LOOP1_MON  = 10'h117;
  localparam logic [IDX_W-1:0] IDX_LOOP2_MON  = 10'h118;
  localparam logic [IDX_W-1:0] IDX_LOOP3_MON  = 10'h119;
  localparam logic [IDX_W-1:0] IDX_REF_1_0    = 10'h126;
  localparam logic [IDX_W-1:0] IDX_REF_3_2    = 10'h127;
  localparam logic [IDX_W-1:0] IDX_FIRST_SYNTHESIZER     = 10'h16e;
  localparam logic [IDX_W-1:0] IDX_EVENT_STAT = 10'h180;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 10'h181;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LOOP_SLOPE_BIT  = 7;
  localparam int LOOP_MEMORY_BIT = 6;
  localparam int LOOP_RANGE_BIT  = 5;
  localparam int LOOP_HOLD_BIT   = 1;
  localparam int LOOP_UNLOCK_BIT = 0;
  localparam int REF_SEL_LSB     = 4;
  localparam int SYN_ALIGN_B_BIT = 5;
  localparam int SYN_ALIGN_A_BIT = 4;
  localparam int SYN_VCO_BIT     = 2;
  localparam int EV_UNLOCK_LSB   = 0;
  localparam int EV_HOLD_LSB     = 3;
  localparam int EV_VCO_BIT      = 6;
  localparam int EV_ALIGN_BIT    = 7;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // Live condition of one digital loop.
  typedef struct packed {
    logic slope_hit;
    logic memory_hit;
    logic range_hit;
    logic holdover_active;
    logic locked;
  } cms_loop_t;

  // Live condition of the first synthesizer.
  typedef struct packed {
    logic enabled;
    logic vco_locked;
    logic out_a_enabled;
    logic out_b_enabled;
    logic align_a_pulse;
    logic align_b_pulse;
  } cms_synth_t;

  // Read channel states.
  typedef enum logic [1:0] {
    CMS_RD_IDLE = 2'b01,
    CMS_RD_DATA = 2'b10
  } cms_rd_state_t;

endpackage : cms_pkg
